// [src/pma_unit.sv]
`timescale 1ns/1ps
// Overview of operation
// - user-0 data access to peripheral traps
// - peripheral accesses ignore range protection
// - cache only cacheable regions with cache enabled
// - no speculative writes; speculative reads only
// - fetch speculation independent of cacheable
// - necessary fetch without fetch property traps
// - necessary data access without data traps
// - precise regions: necessary accesses, in order
// - non-cached speculative: line buffer allowed
// - cacheable speculative: full line speculation
// - other property combinations are reserved
// - sixteen segments indexed by top nibble
// - top segment fixed peripheral, read-only
// - scratchpad segments only cacheable or non-cacheable
// - reset loads default attribute map
// - two-bit code decode table
// - segment n bits at 16+n and n
// - core register read/write, write needs lock released
// - four scratchpad regions decoded
// - cacheable affects all ranges except local scratchpad
// - permitted accesses also need attribute permission
// - unimplemented or misaligned accesses invalid
module pma_unit
  import pma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pma_pkg::csr_req_type csr_req,
  input wire logic init_end_write_lock,
  output logic [31:0] csr_rdata,
  output logic csr_rvalid,
  input wire logic icache_on,
  input wire logic dcache_on,
  input wire pma_pkg::access_type acc,
  output pma_pkg::verdict_type verdict,
  output pma_pkg::props_type props,
  output pma_pkg::trap_type trap,
  output logic [31:0] segment_attribute_map
);
  import pma_pkg::*;

  logic [31:0] map_r;
  logic [31:0] map_nxt;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic [3:0] seg;
  logic [1:0] segment_attr_code;
  props_type p;
  scratch_region_type region;
  logic bypass;
  logic periph_deny;
  logic attr_permit;
  logic may_cache_raw;

  // -----------------------------
  // helpers
  // -----------------------------
  function automatic logic [1:0] seg_code(input logic [31:0] m,
                                          input logic [3:0] n);
    seg_code = {m[HI_BIT_BASE + int'(n)], m[n]};
  endfunction

  function automatic logic [31:0] put_code(input logic [31:0] m,
                                           input logic [3:0] n,
                                           input logic [1:0] c);
    logic [31:0] r;
    r = m;
    r[HI_BIT_BASE + int'(n)] = c[1];
    r[n] = c[0];
    put_code = r;
  endfunction

  // -----------------------------
  // attribute register write filter
  // -----------------------------
  always_comb
  begin
    map_nxt = (map_r & ~SEG_ATTR_MAP_WMASK) |
              (csr_req.wdata & SEG_ATTR_MAP_WMASK);
    map_nxt = put_code(map_nxt, SEG_PERIPH_FIXED, ATTR_PERIPH);
    // scratchpad segments refuse peripheral or reserved codes
    if (seg_code(map_nxt, SEG_PROG_SCRATCH) >= ATTR_PERIPH)
      map_nxt = put_code(map_nxt, SEG_PROG_SCRATCH,
                         seg_code(map_r, SEG_PROG_SCRATCH));
    if (seg_code(map_nxt, SEG_DATA_SCRATCH) >= ATTR_PERIPH)
      map_nxt = put_code(map_nxt, SEG_DATA_SCRATCH,
                         seg_code(map_r, SEG_DATA_SCRATCH));
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      map_r <= SEG_ATTR_MAP_RESET;
    else if (clk_en && csr_req.wr && !init_end_write_lock &&
             csr_req.addr == SEG_ATTR_MAP_OFFSET)
      map_r <= map_nxt;
  end

  // -----------------------------
  // register read
  // -----------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      rvalid_r <= csr_req.rd;
      if (csr_req.rd)
        rdata_r <= (csr_req.addr == SEG_ATTR_MAP_OFFSET) ? map_r : '0;
    end
  end

  assign csr_rdata = rdata_r;
  assign csr_rvalid = rvalid_r;
  assign segment_attribute_map = map_r;

  // -----------------------------
  // segment lookup
  // -----------------------------
  assign seg = acc.addr[SEG_IDX_MSB:SEG_IDX_LSB];
  assign segment_attr_code = seg_code(map_r, seg);

  pma_attr_decode u_decode
  (
    .code (segment_attr_code),
    .props (p)
  );

  pma_scratch_decode u_scratch
  (
    .addr (acc.addr),
    .region (region),
    .prog_side ()
  );

  assign props = p;

  // -----------------------------
  // access checks
  // -----------------------------
  assign bypass = p.periph;
  assign periph_deny = p.periph && !acc.fetch &&
                       acc.priv == PRIV_USER0;
  assign attr_permit = acc.fetch ? p.fetch : p.data;

  // caching: local scratchpad unaffected by cacheable setting
  always_comb
  begin
    may_cache_raw = p.cacheable &&
                    (acc.fetch ? icache_on : dcache_on);
    if (region == REGION_LOCAL)
      may_cache_raw = 1'b0;
  end

  always_comb
  begin
    verdict = '0;
    verdict.range_bypass = bypass;
    verdict.region = region;
    verdict.image_access = (region == REGION_IMAGE);
    verdict.invalid = acc.unimplemented || acc.misaligned;
    verdict.proceed = acc.valid && (acc.range_permit || bypass) &&
                      attr_permit && !periph_deny &&
                      !verdict.invalid;
    verdict.may_cache = may_cache_raw;
    // fetch speculation depends only on the fetch property
    verdict.may_spec_read = acc.fetch ? p.fetch
                            : (p.speculative && !acc.write);
    if (acc.fetch)
    begin
      verdict.mode = DMODE_PRECISE;
      verdict.in_order = 1'b0;
    end
    else if (!p.cacheable && !p.speculative)
    begin
      verdict.mode = DMODE_PRECISE;
      verdict.in_order = 1'b1;
    end
    else if (!p.periph && !p.cacheable && p.speculative)
    begin
      verdict.mode = DMODE_NONCACHED;
      verdict.may_line_buffer = !acc.write;
    end
    else if (!p.periph && p.cacheable && p.speculative)
    begin
      verdict.mode = DMODE_FULLSPEC;
      verdict.may_line_buffer = !acc.write;
    end
    else
    begin
      verdict.mode = DMODE_RESERVED;
      verdict.in_order = 1'b1;
    end
  end

  // -----------------------------
  // traps
  // -----------------------------
  always_comb
  begin
    trap = '0;
    if (acc.valid && acc.necessary)
    begin
      trap.fetch_err = acc.fetch && !p.fetch;
      trap.data_err = !acc.fetch && !p.data;
      trap.periph_priv = periph_deny;
    end
  end
endmodule

// [src/pma_pkg.sv]
package pma_pkg;
  // -----------------------------
  // register map
  // -----------------------------
  localparam logic [15:0] SEG_ATTR_MAP_OFFSET = 16'h801C;
  localparam logic [31:0] SEG_ATTR_MAP_RESET = 32'hC00003FF;
  localparam logic [31:0] SEG_ATTR_MAP_WMASK = 32'h7FFF7FFF;
  localparam int HI_BIT_BASE = 16;
  localparam int SEG_COUNT = 16;
  localparam int SEG_IDX_MSB = 31;
  localparam int SEG_IDX_LSB = 28;
  // -----------------------------
  // attribute codes and segments
  // -----------------------------
  localparam logic [1:0] ATTR_NONCACHE = 2'h0;
  localparam logic [1:0] ATTR_CACHE = 2'h1;
  localparam logic [1:0] ATTR_PERIPH = 2'h2;
  localparam logic [1:0] ATTR_RSVD = 2'h3;
  localparam logic [3:0] SEG_PROG_SCRATCH = 4'hC;
  localparam logic [3:0] SEG_DATA_SCRATCH = 4'hD;
  localparam logic [3:0] SEG_PERIPH_FIXED = 4'hF;
  localparam int IMAGE_BIT = 27;

  typedef enum logic [1:0]
  {
    REGION_NONE,
    REGION_LOCAL,
    REGION_IMAGE
  } scratch_region_type;

  typedef enum logic [1:0]
  {
    PRIV_USER0,
    PRIV_USER1,
    PRIV_SUPER
  } priv_type;

  typedef enum logic [1:0]
  {
    DMODE_PRECISE,
    DMODE_NONCACHED,
    DMODE_FULLSPEC,
    DMODE_RESERVED
  } data_mode_type;

  typedef struct packed
  {
    logic periph;
    logic cacheable;
    logic speculative;
    logic fetch;
    logic data;
  } props_type;

  typedef struct packed
  {
    logic valid;
    logic fetch;
    logic write;
    priv_type priv;
    logic [31:0] addr;
    logic necessary;
    logic misaligned;
    logic unimplemented;
    logic range_permit;
  } access_type;

  typedef struct packed
  {
    logic proceed;
    logic invalid;
    logic may_cache;
    logic may_spec_read;
    logic may_line_buffer;
    logic in_order;
    logic range_bypass;
    data_mode_type mode;
    scratch_region_type region;
    logic image_access;
  } verdict_type;

  typedef struct packed
  {
    logic fetch_err;
    logic data_err;
    logic periph_priv;
  } trap_type;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } csr_req_type;
endpackage

// [src/pma_attr_decode.sv]
`timescale 1ns/1ps
module pma_attr_decode
  import pma_pkg::*;
(
  input wire logic [1:0] code,
  output props_type props
);
  // -----------------------------
  // code to properties
  // -----------------------------
  always_comb
  begin
    props = '0;
    unique case (code)
      ATTR_NONCACHE:
      begin
        props.speculative = 1'b1;
        props.fetch = 1'b1;
        props.data = 1'b1;
      end
      ATTR_CACHE:
      begin
        props.cacheable = 1'b1;
        props.speculative = 1'b1;
        props.fetch = 1'b1;
        props.data = 1'b1;
      end
      ATTR_PERIPH:
      begin
        props.periph = 1'b1;
        props.data = 1'b1;
      end
      ATTR_RSVD:
      begin
        props = '0;
      end
    endcase
  end
endmodule

// [src/pma_scratch_decode.sv]
`timescale 1ns/1ps
module pma_scratch_decode
  import pma_pkg::*;
(
  input wire logic [31:0] addr,
  output scratch_region_type region,
  output logic prog_side
);
  // -----------------------------
  // scratchpad regions
  // -----------------------------
  always_comb
  begin
    region = REGION_NONE;
    prog_side = 1'b0;
    if (addr[SEG_IDX_MSB:SEG_IDX_LSB] == SEG_PROG_SCRATCH ||
        addr[SEG_IDX_MSB:SEG_IDX_LSB] == SEG_DATA_SCRATCH)
    begin
      prog_side = (addr[SEG_IDX_MSB:SEG_IDX_LSB] == SEG_PROG_SCRATCH);
      region = addr[IMAGE_BIT] ? REGION_IMAGE : REGION_LOCAL;
    end
  end
endmodule

// [bench/core_req_model.sv]
`timescale 1ns/1ps
module core_req_model
(
  input wire logic sys_clk,
  input wire logic [3:0] seg,
  input wire logic fetch,
  input wire pma_pkg::priv_type priv,
  input wire logic bad,
  output pma_pkg::access_type acc
);
  import pma_pkg::*;
  // ----------------------------
  // core request, one per edge
  // ----------------------------
  always @(posedge sys_clk)
  begin
    acc.valid <= 1'b1;
    acc.fetch <= fetch;
    acc.write <= !fetch && 1'($urandom);
    acc.priv <= priv;
    acc.addr <= {seg, 28'($urandom)};
    acc.necessary <= 1'b1;
    acc.misaligned <= bad;
    acc.unimplemented <= 1'b0;
    acc.range_permit <= 1'b1;
  end
endmodule

// [bench/pma_properties.sv]
`timescale 1ns/1ps
module pma_properties
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pma_pkg::csr_req_type csr_req,
  input wire logic init_end_write_lock,
  input wire logic csr_rvalid,
  input wire pma_pkg::access_type acc,
  input wire pma_pkg::verdict_type verdict,
  input wire pma_pkg::props_type props,
  input wire pma_pkg::trap_type trap,
  input wire logic [31:0] segment_attribute_map
);
  import pma_pkg::*;
  logic [1:0] code;
  logic need;
  assign code = {segment_attribute_map[16+acc.addr[31:28]],
    segment_attribute_map[acc.addr[31:28]]};
  assign need = acc.valid && acc.necessary;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_read;
    clk_en && csr_req.rd && csr_req.addr == SEG_ATTR_MAP_OFFSET;
  endsequence
  sequence s_locked_wr;
    clk_en && csr_req.wr && init_end_write_lock;
  endsequence
  AST_PRIV: assert property (need && !acc.fetch && props.periph &&
    acc.priv == PRIV_USER0 |-> trap.periph_priv && !verdict.proceed)
    else $error("user0 peripheral access not trapped");
  AST_BYPASS: assert property (props.periph |-> verdict.range_bypass)
    else $error("peripheral access not bypassing ranges");
  AST_CACHE: assert property (verdict.may_cache |-> props.cacheable)
    else $error("caching allowed in uncacheable region");
  AST_FETCH: assert property (need && acc.fetch && !props.fetch
    |-> trap.fetch_err) else $error("fetch error trap missing");
  AST_DATA: assert property (need && !acc.fetch && !props.data
    |-> trap.data_err) else $error("data error trap missing");
  AST_TOP: assert property ({segment_attribute_map[31],
    segment_attribute_map[15]} == ATTR_PERIPH)
    else $error("top segment not peripheral");
  AST_DECODE: assert property (acc.valid |->
    props.periph == (code == ATTR_PERIPH) &&
    props.cacheable == (code == ATTR_CACHE) &&
    props.data == (code != ATTR_RSVD)) else $error("code decode wrong");
  AST_READ: assert property (s_read |=> csr_rvalid)
    else $error("read answer missing");
  AST_LOCK: assert property (s_locked_wr |=>
    $stable(segment_attribute_map)) else $error("locked write landed");
  AST_INVALID: assert property (acc.valid && acc.misaligned
    |-> !verdict.proceed) else $error("misaligned access proceeded");
  AST_SPEC: assert property (acc.valid && acc.write |->
    !verdict.may_spec_read && !verdict.may_line_buffer)
    else $error("speculation allowed on a write");
  AST_FREEZE: assert property (!clk_en |=>
    $stable(segment_attribute_map) && $stable(csr_rvalid))
    else $error("state moved with clock enable low");
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import pma_pkg::*;
  logic sys_clk = 0, rst_n = 0, clk_en = 1, lock = 1, ic = 0, dc = 0;
  logic fe = 0, bad = 0;
  logic [3:0] seg = 0;
  priv_type pr = PRIV_USER0;
  csr_req_type rq = '0;
  logic [31:0] rdata, map, em;
  logic rvalid;
  access_type acc;
  verdict_type vd;
  props_type pp;
  trap_type tp;
  logic [31:0] q[$];
  int err_count = 0, checked = 0;
  logic [1:0] c;
  logic sp, lc, pv;
  scratch_region_type rg;
  data_mode_type md;
  always #2 sys_clk = ~sys_clk;
  pma_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .csr_req(rq), .init_end_write_lock(lock), .csr_rdata(rdata),
    .csr_rvalid(rvalid), .icache_on(ic), .dcache_on(dc), .acc(acc),
    .verdict(vd), .props(pp), .trap(tp), .segment_attribute_map(map));
  core_req_model core (.sys_clk(sys_clk), .seg(seg), .fetch(fe),
    .priv(pr), .bad(bad), .acc(acc));
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] a, logic [31:0] d);
    @(negedge sys_clk);
    rq = '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w)
      q.push_back(em);
    @(negedge sys_clk);
    rq = '0;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] o, w);
    logic [31:0] r;
    r = (w & SEG_ATTR_MAP_WMASK) | (o & ~SEG_ATTR_MAP_WMASK);
    for (int n = 12; n < 14; n++)
      if (w[16+n])
      begin
        r[16+n] = o[16+n];
        r[n] = o[n];
      end
    return r;
  endfunction
  // ----------------------------
  // read answers off the queue
  // ----------------------------
  always @(negedge sys_clk)
    if (rvalid === 1'b1)
    begin
      if (q.size() == 0)
        chk("unexpected read", 0, 1);
      else
        chk("csr_rdata", rdata, q.pop_front());
    end
  initial
  begin
    #40000;
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hFD4CE83D));
    em = SEG_ATTR_MAP_RESET;
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    bus(0, SEG_ATTR_MAP_OFFSET, 0);
    bus(1, SEG_ATTR_MAP_OFFSET, 0);
    bus(0, SEG_ATTR_MAP_OFFSET, 0);
    lock = 0;
    for (int i = 0; i < 6; i++)
    begin
      logic [31:0] w;
      w = i == 0 ? 32'h200C100A : $urandom;
      bus(1, SEG_ATTR_MAP_OFFSET, w);
      em = nxt(em, w);
      bus(1, 16'h8020, ~w);
      bus(0, SEG_ATTR_MAP_OFFSET, 0);
      if (i == 0)
      begin
        $display("register test done");
        for (int k = 0; k < 96; k++)
        begin
          seg = k[3:0];
          fe = k[4];
          pr = k[5] ? PRIV_SUPER : PRIV_USER0;
          bad = k[6];
          ic = 1'($urandom);
          dc = 1'($urandom);
          c = {em[16+k[3:0]], em[k[3:0]]};
          sp = seg inside {SEG_PROG_SCRATCH, SEG_DATA_SCRATCH};
          md = (fe | c[1]) ? DMODE_PRECISE
               : c[0] ? DMODE_FULLSPEC : DMODE_NONCACHED;
          @(negedge sys_clk);
          @(negedge sys_clk);
          lc = !(sp & !acc.addr[27]) & (fe ? ic : dc);
          rg = !sp ? REGION_NONE
               : acc.addr[27] ? REGION_IMAGE : REGION_LOCAL;
          pv = !bad & (fe ? !c[1] : c != 3) & !(!fe & c == 2 & !k[5]);
          chk("props", pp, {c == 2, c == 1, !c[1], !c[1], c != 3});
          chk("fetch_err", tp.fetch_err, fe & c[1]);
          chk("data_err", tp.data_err, !fe & c == 3);
          chk("periph_priv", tp.periph_priv, !fe & c == 2 & !k[5]);
          chk("may_cache", vd.may_cache, c == 1 & lc);
          chk("proceed", vd.proceed, pv);
          chk("region", vd.region, rg);
          chk("mode", vd.mode, md);
          chk("in_order", vd.in_order, !fe & c[1]);
          chk("spec_read", vd.may_spec_read, !c[1] & !acc.write);
          chk("line_buf", vd.may_line_buffer, !fe & !c[1] & !acc.write);
          chk("range_bypass", vd.range_bypass, c == 2);
        end
        bad = 0;
        $display("access test done");
      end
    end
    @(negedge sys_clk);
    clk_en = 0;
    bus(1, SEG_ATTR_MAP_OFFSET, ~em);
    clk_en = 1;
    chk("frozen map", map, em);
    $display("enable test done");
    rst_n = 0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    em = SEG_ATTR_MAP_RESET;
    chk("map after reset", map, em);
    bus(0, SEG_ATTR_MAP_OFFSET, 0);
    $display("reset test done");
    repeat (3) @(negedge sys_clk);
    tally_and_finish();
  end
endmodule
bind pma_unit pma_properties chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .clk_en(clk_en), .csr_req(csr_req),
  .init_end_write_lock(init_end_write_lock), .csr_rvalid(csr_rvalid),
  .acc(acc), .verdict(verdict), .props(props), .trap(trap),
  .segment_attribute_map(segment_attribute_map));
